// [shared/motor_cfg_map.svh]
// Register offsets, field masks, reset values and timing counts of the config bank
`ifndef MOTOR_CFG_MAP_SVH
`define MOTOR_CFG_MAP_SVH

// ***************************************************************
// Register offsets (6-bit serial address)
// ***************************************************************
`define OFS_LOCK        6'h03
`define OFS_CLEAR       6'h04
`define OFS_RECIRC      6'h07
`define OFS_REGULATOR   6'h08
`define OFS_MOTION      6'h09
`define OFS_FEEDBACK    6'h0a
`define OFS_PHASE       6'h0b

// ***************************************************************
// Reset values and writable-bit masks
// ***************************************************************
`define CFG_RESET_VAL   8'h00
`define MASK_RECIRC     8'hff
`define MASK_REGULATOR  8'h3f
`define MASK_MOTION     8'h1f
`define MASK_FEEDBACK   8'hdf
`define MASK_PHASE      8'h07
`define CLEAR_BIT       0

// ***************************************************************
// Lock patterns
// ***************************************************************
`define LOCK_PATTERN    3'h6
`define UNLOCK_PATTERN  3'h3

// ***************************************************************
// Timing: clock rate and millisecond figures
// ***************************************************************
`define CLK_FREQ_HZ     40000000
`define TICK_PERIOD_MS  1
`define MS_PER_S        1000
`define STALL_DET0_MS   13'd300
`define STALL_DET1_MS   13'd500
`define STALL_DET2_MS   13'd1000
`define STALL_DET3_MS   13'd5000
`define RETRY0_MS       13'd500
`define RETRY1_MS       13'd5000

// ***************************************************************
// Speed feedback: commutation edges per output toggle
// ***************************************************************
`define FB_EDGES_X3     4'd1
`define FB_EDGES_X1     4'd3
`define FB_EDGES_X05    4'd6
`define FB_EDGES_X025   4'd12

// ***************************************************************
// Serial frame layout
// ***************************************************************
`define FRAME_BITS      5'd16
`define ADDR_LAST_FALL  5'd6
`define DATA_FIRST_RISE 5'd8

`endif

// [shared/motor_cfg_pkg.sv]
// Types of the motor drive configuration bank and its serial port
package motor_cfg_pkg;

  // ***************************************************************
  // Register layouts
  // ***************************************************************
  typedef struct packed {
    logic       rsv7;
    logic       limit_recirc_path;
    logic       rsv5;
    logic       rsv4;
    logic       async_rectify_active_en;
    logic       sync_rectify_active_en;
    logic [1:0] rsv1_0;
  } recirc_reg_t;

  typedef struct packed {
    logic [1:0] rsv7_6;
    logic       rsv5;
    logic       regulator_sequencing_off;
    logic       regulator_current_limit;
    logic [1:0] regulator_voltage_sel;
    logic       regulator_off;
  } regulator_reg_t;

  typedef struct packed {
    logic [2:0] rsv7_5;
    logic       position_comparator_hysteresis;
    logic       stop_coast_sel;
    logic       coast_en;
    logic       rsv1;
    logic       dir_ccw;
  } motion_reg_t;

  typedef struct packed {
    logic [1:0] speed_feedback_divider;
    logic       rsv5;
    logic       stall_retry_wait;
    logic [1:0] stall_detect_time;
    logic [1:0] stall_response_sel;
  } feedback_reg_t;

  typedef struct packed {
    logic [4:0] rsv7_3;
    logic [2:0] commutation_lead_angle;
  } phase_reg_t;

  typedef struct packed {
    recirc_reg_t    recirc;
    regulator_reg_t regulator;
    motion_reg_t    motion;
    feedback_reg_t  feedback;
    phase_reg_t     phase;
  } cfg_t;

  // ***************************************************************
  // Serial frame: read flag, address, parity, data
  // ***************************************************************
  typedef struct packed {
    logic       rd;
    logic [5:0] addr;
    logic       parity;
    logic [7:0] data;
  } spi_frame_t;

  // ***************************************************************
  // Stall supervisor states
  // ***************************************************************
  typedef enum logic [1:0] {
    ST_MONITOR = 2'b00,
    ST_LATCHED = 2'b01,
    ST_RETRY   = 2'b10
  } stall_state_t;

  // ***************************************************************
  // Module state records
  // ***************************************************************
  typedef struct packed {
    logic [1:0] sclk_s;
    logic [1:0] cs_s;
    logic [1:0] sdi_s;
    logic       sclk_prev;
    logic       cs_prev;
    logic [4:0] fall_cnt;
    logic [4:0] rise_cnt;
    logic [15:0] rx;
    logic [15:0] tx;
    logic [5:0] addr;
    logic       sdo;
    logic       sdo_oe;
    logic       done;
    spi_frame_t frame;
  } spi_state_t;

  typedef struct packed {
    cfg_t         cfg;
    logic [2:0]   lock_val;
    logic         locked;
    logic         clr;
    logic [15:0]  ms_div;
    logic         ms_tick;
    logic [12:0]  stall_ms;
    logic [12:0]  retry_ms;
    stall_state_t st;
    logic         stall_fault;
    logic         stall_flag;
    logic [3:0]   fb_cnt;
    logic         fb_out;
  } bank_state_t;

endpackage

// [design/spi_frame_port.sv]
// Serial configuration port: 16-bit frames, sampled on falling SCLK
`timescale 1ns/1ps
`include "motor_cfg_map.svh"

module spi_frame_port (
  input  wire logic                      clk_sys,    // System clock
  input  wire logic                      rst_b,      // Synchronous reset, active low
  input  wire logic                      sclk,       // Serial clock pin
  input  wire logic                      cs_b,       // Chip select pin, active low
  input  wire logic                      sdi,        // Serial data in pin
  input  wire logic [7:0]                status,     // Status byte sent first
  input  wire logic [7:0]                rd_data,    // Read data for addr
  output logic                           sdo,        // Serial data out
  output logic                           sdo_oe,     // Drive enable of sdo
  output logic [5:0]                     addr,       // Address of the frame in flight
  output logic                           frame_done, // One-cycle pulse, full frame
  output motor_cfg_pkg::spi_frame_t      frame       // Captured frame
);

  motor_cfg_pkg::spi_state_t q;  // Registered state
  motor_cfg_pkg::spi_state_t n;  // Next state

  logic sclk_rise;  // Synchronised rising edge
  logic sclk_fall;  // Synchronised falling edge
  logic cs_fall;    // Frame start
  logic cs_rise;    // Frame end

  // ***************************************************************
  // Next-state logic
  // ***************************************************************
  // Edges are taken from the second sync stage only
  always_comb begin
    n          = q;
    n.done     = 1'b0;
    n.sclk_s   = {q.sclk_s[0], sclk};
    n.cs_s     = {q.cs_s[0], cs_b};
    n.sdi_s    = {q.sdi_s[0], sdi};
    n.sclk_prev = q.sclk_s[1];
    n.cs_prev  = q.cs_s[1];
    sclk_rise  = q.sclk_s[1] & ~q.sclk_prev;
    sclk_fall  = ~q.sclk_s[1] & q.sclk_prev;
    cs_fall    = ~q.cs_s[1] & q.cs_prev;
    cs_rise    = q.cs_s[1] & ~q.cs_prev;
    if (cs_fall) begin
      // New frame: status byte goes out first
      n.fall_cnt = 5'd0;
      n.rise_cnt = 5'd0;
      n.tx       = {status, 8'h00};
      n.sdo_oe   = 1'b1;
      n.sdo      = 1'b0;
    end else if (cs_rise) begin
      // Only a frame of exactly sixteen bits is passed on
      n.done   = (q.fall_cnt == `FRAME_BITS);
      n.frame  = motor_cfg_pkg::spi_frame_t'(q.rx);
      n.sdo_oe = 1'b0;
      n.sdo    = 1'b0;
    end else if (!q.cs_s[1]) begin
      if (sclk_rise && q.rise_cnt != 5'h1f) begin
        // Launch next bit; read data replaces the shifter at bit 8
        n.rise_cnt = q.rise_cnt + 5'd1;
        if (q.rise_cnt == `DATA_FIRST_RISE) begin
          n.sdo = rd_data[7];
          n.tx  = {rd_data[6:0], 9'h000};
        end else begin
          n.sdo = q.tx[15];
          n.tx  = {q.tx[14:0], 1'b0};
        end
      end
      if (sclk_fall && q.fall_cnt != 5'h1f) begin
        // Sample host data; address is complete after seven bits
        n.fall_cnt = q.fall_cnt + 5'd1;
        n.rx       = {q.rx[14:0], q.sdi_s[1]};
        if (q.fall_cnt == `ADDR_LAST_FALL) begin
          n.addr = {q.rx[4:0], q.sdi_s[1]};
        end
      end
    end
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      q <= '0;
      q.sclk_s <= 2'h0;
      q.cs_s <= 2'h3;
      q.cs_prev <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign sdo        = q.sdo;
  assign sdo_oe     = q.sdo_oe;
  assign addr       = q.addr;
  assign frame_done = q.done;
  assign frame      = q.frame;

endmodule

// [design/motor_drive_config_regs.sv]
// Motor drive configuration bank with lock, fault clear and stall supervisor
// Behaviour
// (R1) Recirc bit 6: 0 brake, 1 coast
// (R2) Recirc bit 3 enables async rectification
// (R3) Recirc bit 2 enables sync rectification
// (R4) Regulator bit 4 disables power-up sequencing
// (R5) Regulator bit 3: 600 mA or 150 mA
// (R6) Regulator bits 2-1 select output voltage
// (R7) Regulator bit 0 turns regulator off
// (R8) Motion bit 4 selects comparator hysteresis
// (R9) Motion bit 3: stop brakes or coasts
// (R10) Motion bit 2 enables coast operation
// (R11) Motion bit 0: clockwise or anticlockwise
// (R12) Feedback bits 7-6 scale speed output
// (R13) Feedback bit 4: retry wait 500/5000 ms
// (R14) Feedback bits 3-2 set stall detect time
// (R15) Feedback bits 1-0 select stall response
// (R16) Phase bits 2-0 set lead angle
// (R17) All five registers reset to zero
// (R18) Pattern 110 locks writes, 011 unlocks
// (R19) Latched fault held until clear written
// (R20) Read-only reserved bits read zero
`timescale 1ns/1ps
`include "motor_cfg_map.svh"

module motor_drive_config_regs #(
  parameter int unsigned CYC_PER_MS = `CLK_FREQ_HZ * `TICK_PERIOD_MS / `MS_PER_S
) (
  input  wire logic                clk_sys,            // System clock, 40 MHz
  input  wire logic                rst_b,              // Synchronous reset, active low
  input  wire logic                sclk,               // Serial clock pin
  input  wire logic                cs_b,               // Serial select pin, active low
  input  wire logic                sdi,                // Serial data in pin
  input  wire logic                comm_edge,          // Commutation step pulse
  input  wire logic                motor_run,          // Motor commanded to spin
  output logic                     sdo,                // Serial data out
  output logic                     sdo_oe,             // Drive enable of sdo
  output motor_cfg_pkg::cfg_t      cfg,                // Stored configuration
  output logic                     reg_locked,         // Config writes ignored
  output logic                     stall_fault,        // Drivers held off by stall
  output logic                     stall_flag,         // Stall reported
  output logic                     speed_feedback_out  // Scaled speed feedback
);

  motor_cfg_pkg::bank_state_t q;  // Registered state
  motor_cfg_pkg::bank_state_t n;  // Next state

  logic                      port_done;   // Frame received
  motor_cfg_pkg::spi_frame_t port_frame;  // Received frame
  logic [5:0]                port_addr;   // Address for readback
  logic [7:0]                rd_data;     // Readback byte
  logic                      wr;          // Write frame this cycle
  logic                      cfg_wr;      // Write to a config offset
  logic                      det_hit;     // Stall time reached
  logic                      set_flag;    // Stall report event

  // ***************************************************************
  // Lookup functions
  // ***************************************************************
  // Stall detection time in ms ticks
  function automatic logic [12:0] det_ms(input logic [1:0] code);
    case (code)
      2'h0:    det_ms = `STALL_DET0_MS;
      2'h1:    det_ms = `STALL_DET1_MS;
      2'h2:    det_ms = `STALL_DET2_MS;
      default: det_ms = `STALL_DET3_MS;
    endcase
  endfunction

  // Retry wait in ms ticks
  function automatic logic [12:0] retry_ms(input logic sel);
    retry_ms = sel ? `RETRY1_MS : `RETRY0_MS;
  endfunction

  // Commutation edges per feedback toggle
  function automatic logic [3:0] fb_edges(input logic [1:0] code);
    case (code)
      2'h0:    fb_edges = `FB_EDGES_X3;
      2'h1:    fb_edges = `FB_EDGES_X1;
      2'h2:    fb_edges = `FB_EDGES_X05;
      default: fb_edges = `FB_EDGES_X025;
    endcase
  endfunction

  // True for offsets of the five config registers
  function automatic logic is_cfg(input logic [5:0] a);
    is_cfg = (a >= `OFS_RECIRC) && (a <= `OFS_PHASE);
  endfunction

  // ***************************************************************
  // Serial port
  // ***************************************************************
  spi_frame_port u_port (
    .clk_sys    (clk_sys),
    .rst_b      (rst_b),
    .sclk       (sclk),
    .cs_b       (cs_b),
    .sdi        (sdi),
    .status     ({6'h00, q.stall_fault, q.stall_flag}),
    .rd_data    (rd_data),
    .sdo        (sdo),
    .sdo_oe     (sdo_oe),
    .addr       (port_addr),
    .frame_done (port_done),
    .frame      (port_frame)
  );

  // ***************************************************************
  // Readback multiplexer
  // ***************************************************************
  // Unmapped offsets and the clear register read as zero
  always_comb begin
    case (port_addr)
      `OFS_LOCK:      rd_data = {5'h00, q.lock_val};
      `OFS_RECIRC:    rd_data = q.cfg.recirc;
      `OFS_REGULATOR: rd_data = q.cfg.regulator;
      `OFS_MOTION:    rd_data = q.cfg.motion;
      `OFS_FEEDBACK:  rd_data = q.cfg.feedback;
      `OFS_PHASE:     rd_data = q.cfg.phase;
      default:        rd_data = 8'h00;
    endcase
  end

  // ***************************************************************
  // Next-state logic
  // ***************************************************************
  always_comb begin
    n        = q;
    n.clr    = 1'b0;
    n.ms_tick = 1'b0;
    set_flag = 1'b0;
    wr       = port_done && !port_frame.rd;
    cfg_wr   = wr && is_cfg(port_frame.addr);

    // Lock field: only the two patterns have an effect
    if (wr && port_frame.addr == `OFS_LOCK) begin
      if (port_frame.data[2:0] == `LOCK_PATTERN) begin
        n.locked   = 1'b1;  // [R18]
        n.lock_val = `LOCK_PATTERN;
      end else if (port_frame.data[2:0] == `UNLOCK_PATTERN) begin
        n.locked   = 1'b0;  // [R18]
        n.lock_val = `UNLOCK_PATTERN;
      end
    end

    // Fault clear is a self-clearing pulse, accepted even while locked
    if (wr && port_frame.addr == `OFS_CLEAR) begin
      n.clr = port_frame.data[`CLEAR_BIT];  // [R19]
    end

    // Config writes are dropped while locked; masks keep R-0 bits at zero
    if (cfg_wr && !q.locked) begin  // [R18]
      case (port_frame.addr)
        `OFS_RECIRC: begin
          n.cfg.recirc = port_frame.data & `MASK_RECIRC;  // [R1] [R2] [R3]
        end
        `OFS_REGULATOR: begin
          n.cfg.regulator = port_frame.data & `MASK_REGULATOR;  // [R4] [R5] [R6] [R7] [R20]
        end
        `OFS_MOTION: begin
          n.cfg.motion = port_frame.data & `MASK_MOTION;  // [R8] [R9] [R10] [R11] [R20]
        end
        `OFS_FEEDBACK: begin
          n.cfg.feedback = port_frame.data & `MASK_FEEDBACK;  // [R12] [R13] [R14] [R15] [R20]
        end
        default: begin
          n.cfg.phase = port_frame.data & `MASK_PHASE;  // [R16] [R20]
        end
      endcase
    end

    // Millisecond enable from the clock divider
    if (q.ms_div >= 16'(CYC_PER_MS - 1)) begin
      n.ms_div  = 16'h0000;
      n.ms_tick = 1'b1;
    end else begin
      n.ms_div = q.ms_div + 16'h0001;
    end

    // Time without commutation while the motor should spin
    det_hit = (q.st == motor_cfg_pkg::ST_MONITOR) && motor_run && !comm_edge &&
              (q.stall_ms >= det_ms(q.cfg.feedback.stall_detect_time));  // [R14]
    if (!motor_run || comm_edge || q.st != motor_cfg_pkg::ST_MONITOR) begin
      n.stall_ms = 13'h0000;
    end else if (q.ms_tick && !det_hit) begin
      n.stall_ms = q.stall_ms + 13'h0001;
    end

    // Stall supervisor
    case (q.st)
      motor_cfg_pkg::ST_MONITOR: begin
        if (det_hit) begin
          case (q.cfg.feedback.stall_response_sel)  // [R15]
            2'h0: begin
              n.st          = motor_cfg_pkg::ST_LATCHED;
              n.stall_fault = 1'b1;
              set_flag      = 1'b1;
            end
            2'h1: begin
              n.st          = motor_cfg_pkg::ST_RETRY;
              n.stall_fault = 1'b1;
              n.retry_ms    = 13'h0000;
              set_flag      = 1'b1;
            end
            2'h2: begin
              set_flag = 1'b1;
            end
            default: begin
              set_flag = 1'b0;
            end
          endcase
        end
      end
      motor_cfg_pkg::ST_LATCHED: begin
        // Held until the host clears it
        if (q.clr) begin  // [R19]
          n.st          = motor_cfg_pkg::ST_MONITOR;
          n.stall_fault = 1'b0;
        end
      end
      motor_cfg_pkg::ST_RETRY: begin
        // Release after the selected wait
        if (q.retry_ms >= retry_ms(q.cfg.feedback.stall_retry_wait)) begin  // [R13]
          n.st          = motor_cfg_pkg::ST_MONITOR;
          n.stall_fault = 1'b0;
        end else if (q.ms_tick) begin
          n.retry_ms = q.retry_ms + 13'h0001;
        end
      end
      default: begin
        n.st          = motor_cfg_pkg::ST_MONITOR;
        n.stall_fault = 1'b0;
      end
    endcase

    // Report flag: a new stall in the clearing cycle wins over the clear
    n.stall_flag = set_flag | (q.stall_flag & ~q.clr);  // [R19]

    // Speed feedback toggles after a code-dependent number of steps
    if (comm_edge) begin
      if (q.fb_cnt >= fb_edges(q.cfg.feedback.speed_feedback_divider) - 4'd1) begin  // [R12]
        n.fb_cnt = 4'h0;
        n.fb_out = ~q.fb_out;
      end else begin
        n.fb_cnt = q.fb_cnt + 4'h1;
      end
    end
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  // Everything, including the five config registers, resets to zero
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      q <= '0;  // [R17]
    end else begin
      q <= n;
    end
  end

  assign cfg                = q.cfg;
  assign reg_locked         = q.locked;
  assign stall_fault        = q.stall_fault;
  assign stall_flag         = q.stall_flag;
  assign speed_feedback_out = q.fb_out;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  property p_reset_zero;  // [R17]
    disable iff (1'b0) !rst_b |=> (q.cfg == '0) && !q.locked && !q.stall_fault;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("config not zero after reset");

  property p_recirc_write;  // [R1] [R2] [R3]
    cfg_wr && !q.locked && port_frame.addr == `OFS_RECIRC |=>
      q.cfg.recirc == $past(port_frame.data);
  endproperty
  a_recirc_write: assert property (p_recirc_write) else $error("recirc write lost");

  property p_ro_zero;  // [R20]
    q.cfg.regulator.rsv7_6 == 2'h0 && q.cfg.motion.rsv7_5 == 3'h0 &&
      q.cfg.feedback.rsv5 == 1'b0 && q.cfg.phase.rsv7_3 == 5'h00;
  endproperty
  a_ro_zero: assert property (p_ro_zero) else $error("read-only bit set");

  property p_locked_hold;  // [R18]
    cfg_wr && q.locked |=> $stable(q.cfg);
  endproperty
  a_locked_hold: assert property (p_locked_hold) else $error("write while locked");

  property p_lock_set;  // [R18]
    wr && port_frame.addr == `OFS_LOCK && port_frame.data[2:0] == `LOCK_PATTERN |=>
      q.locked ##1 (q.locked || $past(wr));
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock pattern ignored");

  property p_latched_hold;  // [R19]
    q.st == motor_cfg_pkg::ST_LATCHED && !q.clr |=>
      q.st == motor_cfg_pkg::ST_LATCHED && q.stall_fault;
  endproperty
  a_latched_hold: assert property (p_latched_hold) else $error("latched fault released");

  property p_latched_clear;  // [R19]
    q.st == motor_cfg_pkg::ST_LATCHED && q.clr |=>
      q.st == motor_cfg_pkg::ST_MONITOR && !q.stall_fault;
  endproperty
  a_latched_clear: assert property (p_latched_clear) else $error("clear did not release");

  property p_detect_latch;  // [R14] [R15]
    det_hit && q.cfg.feedback.stall_response_sel == 2'h0 |=>
      q.st == motor_cfg_pkg::ST_LATCHED && q.stall_fault && q.stall_flag;
  endproperty
  a_detect_latch: assert property (p_detect_latch) else $error("stall not latched");

  property p_report_only;  // [R15]
    det_hit && q.cfg.feedback.stall_response_sel == 2'h2 |=> q.stall_flag && !q.stall_fault;
  endproperty
  a_report_only: assert property (p_report_only) else $error("report-only mode acted");

  property p_retry_end;  // [R13]
    q.st == motor_cfg_pkg::ST_RETRY &&
      q.retry_ms >= retry_ms(q.cfg.feedback.stall_retry_wait) |=>
      q.st == motor_cfg_pkg::ST_MONITOR && !q.stall_fault;
  endproperty
  a_retry_end: assert property (p_retry_end) else $error("retry wait overrun");

  property p_fb_toggle;  // [R12]
    comm_edge && q.cfg.feedback.speed_feedback_divider == 2'h0 |=>
      q.fb_out != $past(q.fb_out);
  endproperty
  a_fb_toggle: assert property (p_fb_toggle) else $error("feedback did not toggle");

endmodule

// [tb/cfg_host.sv]
// Host model: drives 16-bit serial frames into the config port
`timescale 1ns/1ps
module cfg_host (
  input  wire logic clk_sys, // System clock, paces every pin change
  input  wire logic sdo,     // Device reply
  output logic      sclk,    // Idles low between frames
  output logic      cs_b,    // Frame select, active low
  output logic      sdi      // Host data
);
  // Pins idle at time zero
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    sdi  = 1'b0;
  end
  // ************************************
  // One frame: levels held 6 clocks, well over the 3-clock sync need
  // ************************************
  task automatic xfer(input logic rd, input logic [5:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    logic [15:0] f;
    logic [15:0] r;
    f = {rd, a, 1'b0, d};
    @(posedge clk_sys) cs_b <= 1'b0;
    for (int k = 15; k >= 0; k--) begin
      repeat (6) @(posedge clk_sys);
      sclk <= 1'b1;
      sdi  <= f[k];
      repeat (6) @(posedge clk_sys);
      r[k] = sdo;
      sclk <= 1'b0;
    end
    repeat (6) @(posedge clk_sys);
    cs_b <= 1'b1;
    sdi  <= ~sdi; // Released line shows no stale bit
    repeat (12) @(posedge clk_sys);
    q = r[7:0];
  endtask
endmodule

// [tb/tb.sv]
// Testbench of the motor drive configuration bank
`timescale 1ns/1ps
module tb;
  logic                clk_sys, rst_b, sclk, cs_b, sdi, sdo, sdo_oe;
  logic                reg_locked, stall_fault, stall_flag, fb, comm_edge, motor_run;
  motor_cfg_pkg::cfg_t cfg;
  int                  err_total, cmp_count;
  logic [7:0]          q;
  logic [7:0]          msk [5] = '{8'hff, 8'h3f, 8'h1f, 8'hdf, 8'h07}; // Writable bits
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Stall and feedback inputs are driven by their own scenarios
  motor_drive_config_regs #(.CYC_PER_MS(4)) motor_drive_config_regs_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .sdi(sdi),
    .comm_edge(comm_edge), .motor_run(motor_run), .sdo(sdo), .sdo_oe(sdo_oe), .cfg(cfg),
    .reg_locked(reg_locked), .stall_fault(stall_fault), .stall_flag(stall_flag),
    .speed_feedback_out(fb));
  cfg_host cfg_host_i (.clk_sys(clk_sys), .sdo(sdo), .sclk(sclk), .cs_b(cs_b), .sdi(sdi));
  // ************************************
  // Shared compare, access and verdict
  // ************************************
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    cfg_host_i.xfer(1'b0, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a);
    cfg_host_i.xfer(1'b1, a, 8'h00, q);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ************************************
  // Scenarios
  // ************************************
  task automatic t_reset;
    cmp8({7'h00, sdo_oe}, 8'h00);
    for (int i = 0; i < 5; i++) begin
      rd(6'h07 + 6'(i));
      cmp8(q, 8'h00);
    end
    $display("reset values done");
  endtask
  // All ones land only in writable bits, both on readback and at cfg
  task automatic t_masks;
    for (int i = 0; i < 5; i++) begin
      wr(6'h07 + 6'(i), 8'hff);
      rd(6'h07 + 6'(i));
      cmp8(q, msk[i]);
      cmp8(cfg[39-8*i -: 8], msk[i]);
      wr(6'h07 + 6'(i), 8'h00);
      cmp8(cfg[39-8*i -: 8], 8'h00);
    end
    $display("masks done");
  endtask
  task automatic t_lock;
    wr(6'h03, 8'h05);
    cmp8({7'h00, reg_locked}, 8'h00);
    wr(6'h03, 8'h06);
    cmp8({7'h00, reg_locked}, 8'h01);
    wr(6'h09, 8'h1f);
    rd(6'h09);
    cmp8(q, 8'h00);
    wr(6'h03, 8'h03);
    cmp8({7'h00, reg_locked}, 8'h00);
    wr(6'h09, 8'h11);
    cmp8(cfg.motion, 8'h11);
    $display("lock done");
  endtask
  task automatic t_unmapped;
    wr(6'h3f, 8'hff);
    rd(6'h3f);
    cmp8(q, 8'h00);
    $display("unmapped done");
  endtask
  // Mode 0 stall latches after 300 ms of ticks and holds until cleared
  task automatic t_stall;
    @(posedge clk_sys) motor_run <= 1'b1;
    repeat (1180) @(posedge clk_sys);
    cmp8({6'h00, stall_fault, stall_flag}, 8'h00);
    repeat (40) @(posedge clk_sys);
    cmp8({6'h00, stall_fault, stall_flag}, 8'h03);
    motor_run <= 1'b0;
    rd(6'h0a);
    cmp8({6'h00, stall_fault, stall_flag}, 8'h03);
    wr(6'h04, 8'h01);
    cmp8({6'h00, stall_fault, stall_flag}, 8'h00);
    $display("stall done");
  endtask
  // One-cycle commutation pulses, an idle edge between them
  task automatic pulse(input int k);
    repeat (k) begin
      @(posedge clk_sys) comm_edge <= 1'b1;
      @(posedge clk_sys) comm_edge <= 1'b0;
    end
    @(posedge clk_sys);
  endtask
  // Feedback toggles on every step at code 0, every third at code 1
  task automatic t_feedback;
    pulse(1);
    cmp8({7'h00, fb}, 8'h01);
    wr(6'h0a, 8'h40);
    pulse(2);
    cmp8({7'h00, fb}, 8'h01);
    pulse(1);
    cmp8({7'h00, fb}, 8'h00);
    $display("feedback done");
  endtask
  // Watchdog: 31 frames of 211 clocks plus a 1220-clock stall fit inside 1 ms
  initial begin
    #1ms;
    err_total++;
    final_report();
  end
  // Reset held 10 clocks, then the scenarios in turn
  initial begin
    rst_b = 1'b0;
    comm_edge = 1'b0;
    motor_run = 1'b0;
    err_total = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_masks();
    t_lock();
    t_unmapped();
    t_stall();
    t_feedback();
    final_report();
  end
endmodule
